// file: dtg_timer.sv
// Contract
// - two 16-bit timers, each two bytes
// - four modes: 13, 16, reload8, split
// - split mode exists only on timer 0
// - clock is system or shared prescaled tick
// - each timer has its own mode field
// - interrupt output gated by per-timer enable
// - 13-bit: high byte plus low bits 4..0
// - wrap to zero sets overflow flag, except a timer 1 wrap while timer 0 is in split
// - count needs run and (no gate or pin active); timer 1 needs no run while timer 0 is in split
// - timer 0 gate pin active low
// - run does not clear the counter
// - timer 1 mirrors timer 0 with own bits
// - 16-bit mode uses all sixteen bits
// - reload8: low counts, reloads from high
// - split: high byte runs on t1 run, sets t1 flag
// - flags cleared by software or vector acknowledge
`timescale 1ns/100ps
module dtg_timer (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // control bits
    input  wire logic       t0_run_i,
    input  wire logic       t1_run_i,
    input  wire logic       t0_gate_enable_i,
    input  wire logic       t1_gate_enable_i,
    input  wire logic [1:0] t0_mode_select_i,
    input  wire logic [1:0] t1_mode_select_i,
    input  wire logic       t0_clk_select_i,
    input  wire logic       t1_clk_select_i,
    input  wire logic [1:0] clock_scale_field_i,
    input  wire logic       t0_irq_enable_i,
    input  wire logic       t1_irq_enable_i,
    // byte writes and flag clears
    input  wire logic [3:0] byte_wr_i,
    input  wire logic [7:0] byte_wdata_i,
    input  wire logic       t0_flag_clr_i,
    input  wire logic       t1_flag_clr_i,
    input  wire logic       t0_vector_ack_i,
    input  wire logic       t1_vector_ack_i,
    // gate pins, port0_pin2 for timer 0
    input  wire logic       ext_irq_in_a_n_i,
    input  wire logic       ext_irq_in_b_n_i,
    // counter bytes and status
    output logic [7:0]      t0_low_byte_o,
    output logic [7:0]      t0_high_byte_o,
    output logic [7:0]      t1_low_byte_o,
    output logic [7:0]      t1_high_byte_o,
    output logic            t0_overflow_flag_o,
    output logic            t1_overflow_flag_o,
    output logic            t0_irq_o,
    output logic            t1_irq_o
);

    logic [7:0] t0_lo_q, t0_lo_d, t0_hi_q, t0_hi_d;
    logic [7:0] t1_lo_q, t1_lo_d, t1_hi_q, t1_hi_d;
    logic       t0_flag_q, t0_flag_d, t1_flag_q, t1_flag_d;
    logic [5:0] presc_q, presc_d, presc_div;
    logic       presc_tick;
    logic       ext_a_q1, ext_a_q2, ext_b_q1, ext_b_q2;
    logic       t0_tick, t1_tick, gate_ok_a, gate_ok_b;
    logic       t0_split, t0_inc, t0h_inc, t1_en, t1_inc;
    logic       t0_ovf, t0h_ovf, t1_ovf, t1_set;
    logic [16:0] t0_step, t1_step;

    // one counting step: returns {overflow, high, low}
    function automatic logic [16:0] dtg_step(input logic [1:0] m,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [12:0] c13;
        logic [15:0] c16;
        logic [7:0]  nh;
        logic [7:0]  nl;
        logic        ovf;
        begin
            c13 = {hi, lo[dtg_pkg::M0_LOW_W-1:0]} + dtg_pkg::CNT13_ONE;
            c16 = {hi, lo} + dtg_pkg::CNT16_ONE;
            nh  = hi;
            nl  = lo;
            ovf = 1'b0;
            case (m)
                dtg_pkg::MODE_13BIT: begin
                    // upper low-byte bits are left as they were; software masks them
                    nh  = c13[12:dtg_pkg::M0_LOW_W];
                    nl  = {lo[7:dtg_pkg::M0_LOW_W], c13[dtg_pkg::M0_LOW_W-1:0]};
                    ovf = &{hi, lo[dtg_pkg::M0_LOW_W-1:0]};
                end
                dtg_pkg::MODE_16BIT: begin
                    nh  = c16[15:8];
                    nl  = c16[7:0];
                    ovf = &{hi, lo};
                end
                dtg_pkg::MODE_RELOAD8: begin
                    ovf = &lo;
                    nl  = ovf ? hi : lo + dtg_pkg::BYTE_ONE;
                end
                default: begin
                    // split: only the low byte here, the high byte is handled apart
                    ovf = &lo;
                    nl  = lo + dtg_pkg::BYTE_ONE;
                end
            endcase
            dtg_step = {ovf, nh, nl};
        end
    endfunction

    // prescaler: shared tick; >= guards a switch to a shorter ratio mid-count
    always_comb begin
        case (dtg_pkg::dtg_scale_type'(clock_scale_field_i))
            dtg_pkg::SCALE_0: presc_div = dtg_pkg::PRESC_DIV_0;
            dtg_pkg::SCALE_1: presc_div = dtg_pkg::PRESC_DIV_1;
            dtg_pkg::SCALE_2: presc_div = dtg_pkg::PRESC_DIV_2;
            default:          presc_div = dtg_pkg::PRESC_DIV_3;
        endcase
        presc_tick = (presc_q >= presc_div - dtg_pkg::PRESC_ONE);
        presc_d    = presc_tick ? dtg_pkg::PRESC_RESET : presc_q + dtg_pkg::PRESC_ONE;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc_q <= dtg_pkg::PRESC_RESET;
        end else begin
            presc_q <= presc_d;
        end
    end

    // gate pins cross in through two flops; idle level is high (inactive)
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_a_q1 <= 1'b1;
            ext_a_q2 <= 1'b1;
            ext_b_q1 <= 1'b1;
            ext_b_q2 <= 1'b1;
        end else begin
            ext_a_q1 <= ext_irq_in_a_n_i;
            ext_a_q2 <= ext_a_q1;
            ext_b_q1 <= ext_irq_in_b_n_i;
            ext_b_q2 <= ext_b_q1;
        end
    end

    // enables and ticks
    always_comb begin
        t0_tick   = t0_clk_select_i | presc_tick;
        t1_tick   = t1_clk_select_i | presc_tick;
        gate_ok_a = !t0_gate_enable_i || !ext_a_q2;
        gate_ok_b = !t1_gate_enable_i || !ext_b_q2;
        t0_split  = (t0_mode_select_i == dtg_pkg::MODE_SPLIT8);
        t0_inc    = t0_run_i && gate_ok_a && t0_tick;
        t0h_inc   = t0_split && t1_run_i && t0_tick;
        // timer 1 has no split mode; it is stopped by selecting it
        t1_en     = (t1_mode_select_i != dtg_pkg::MODE_SPLIT8) && gate_ok_b
                    && (t0_split || t1_run_i);
        t1_inc    = t1_en && t1_tick;
    end

    // counter next values; a byte write wins over a count in the same cycle
    always_comb begin
        t0_step = t0_inc ? dtg_step(t0_mode_select_i, t0_hi_q, t0_lo_q)
                         : {1'b0, t0_hi_q, t0_lo_q};
        t1_step = t1_inc ? dtg_step(t1_mode_select_i, t1_hi_q, t1_lo_q)
                         : {1'b0, t1_hi_q, t1_lo_q};
        t0_ovf  = t0_step[16];
        t1_ovf  = t1_step[16];
        t0h_ovf = t0h_inc && (&t0_hi_q);
        t0_lo_d = t0_step[7:0];
        t0_hi_d = t0_split ? (t0h_inc ? t0_hi_q + dtg_pkg::BYTE_ONE : t0_hi_q)
                           : t0_step[15:8];
        t1_lo_d = t1_step[7:0];
        t1_hi_d = t1_step[15:8];
        if (byte_wr_i[dtg_pkg::BYTE_T0_LOW]) begin
            t0_lo_d = byte_wdata_i;
        end
        if (byte_wr_i[dtg_pkg::BYTE_T0_HIGH]) begin
            t0_hi_d = byte_wdata_i;
        end
        if (byte_wr_i[dtg_pkg::BYTE_T1_LOW]) begin
            t1_lo_d = byte_wdata_i;
        end
        if (byte_wr_i[dtg_pkg::BYTE_T1_HIGH]) begin
            t1_hi_d = byte_wdata_i;
        end
    end

    // overflow flags: a set in the clearing cycle wins
    always_comb begin
        t1_set    = (t1_ovf && !t0_split) || t0h_ovf;
        t0_flag_d = t0_flag_q;
        t1_flag_d = t1_flag_q;
        if (t0_ovf) begin
            t0_flag_d = 1'b1;
        end else if (t0_flag_clr_i || t0_vector_ack_i) begin
            t0_flag_d = 1'b0;
        end
        if (t1_set) begin
            t1_flag_d = 1'b1;
        end else if (t1_flag_clr_i || t1_vector_ack_i) begin
            t1_flag_d = 1'b0;
        end
    end

    // run never clears the count; byte writes and the reload8 overflow load it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            t0_lo_q   <= dtg_pkg::BYTE_RESET;
            t0_hi_q   <= dtg_pkg::BYTE_RESET;
            t1_lo_q   <= dtg_pkg::BYTE_RESET;
            t1_hi_q   <= dtg_pkg::BYTE_RESET;
            t0_flag_q <= 1'b0;
            t1_flag_q <= 1'b0;
        end else begin
            t0_lo_q   <= t0_lo_d;
            t0_hi_q   <= t0_hi_d;
            t1_lo_q   <= t1_lo_d;
            t1_hi_q   <= t1_hi_d;
            t0_flag_q <= t0_flag_d;
            t1_flag_q <= t1_flag_d;
        end
    end

    // outputs
    assign t0_low_byte_o      = t0_lo_q;
    assign t0_high_byte_o     = t0_hi_q;
    assign t1_low_byte_o      = t1_lo_q;
    assign t1_high_byte_o     = t1_hi_q;
    assign t0_overflow_flag_o = t0_flag_q;
    assign t1_overflow_flag_o = t1_flag_q;
    assign t0_irq_o           = t0_flag_q && t0_irq_enable_i;
    assign t1_irq_o           = t1_flag_q && t1_irq_enable_i;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_flag_on_wrap: assert property (t0_ovf |=> t0_flag_q)
        else $error("t0 overflow did not set flag");
    a_irq_gating: assert property (t0_irq_o == (t0_flag_q && t0_irq_enable_i)
                                   && t1_irq_o == (t1_flag_q && t1_irq_enable_i))
        else $error("irq not gated by enable");
    a_hold_idle: assert property (!t0_inc && !t0_split && byte_wr_i == 4'h0
                                  |=> $stable(t0_lo_q) && $stable(t0_hi_q))
        else $error("t0 changed while disabled");
    a_gate_blocks: assert property (t0_gate_enable_i && ext_a_q2 |-> !t0_inc)
        else $error("t0 counted with gate pin high");
    a_reload_low: assert property (t0_mode_select_i == dtg_pkg::MODE_RELOAD8 && t0_ovf
                                   && byte_wr_i == 4'h0
                                   |=> t0_lo_q == $past(t0_hi_q) && $stable(t0_hi_q))
        else $error("reload mode did not reload low byte");
    a_split_flag: assert property (t0h_ovf |=> t1_flag_q)
        else $error("split high overflow missed t1 flag");
    a_step_sixteen: assert property (t0_inc && t0_mode_select_i == dtg_pkg::MODE_16BIT
                                     && byte_wr_i == 4'h0
                                     |=> {t0_hi_q, t0_lo_q}
                                         == $past({t0_hi_q, t0_lo_q}) + 16'h0001)
        else $error("16-bit step not one");
    a_wrap_thirteen: assert property (t0_inc && t0_mode_select_i == dtg_pkg::MODE_13BIT
                                      && t0_hi_q == 8'hFF && t0_lo_q[4:0] == 5'h1F
                                      && byte_wr_i == 4'h0
                                      ##1 1'b1 |-> t0_hi_q == 8'h00 && t0_lo_q[4:0] == 5'h00
                                      && t0_flag_q)
        else $error("13-bit wrap wrong");
    a_flag_clear: assert property (t1_flag_clr_i && !t1_set |=> !t1_flag_q)
        else $error("t1 flag not cleared");
    a_run_needed: assert property (!t0_run_i |-> !t0_inc)
        else $error("t0 counted without run");
    a_t1_split_off: assert property (t1_mode_select_i == dtg_pkg::MODE_SPLIT8 |-> !t1_inc)
        else $error("timer 1 counted in split mode");

    c_t0_wrap: cover property (t0_ovf ##1 t0_irq_o);
    c_reload: cover property (t0_mode_select_i == dtg_pkg::MODE_RELOAD8 && t0_ovf);
    c_split_hi: cover property (t0h_ovf);
    c_gated: cover property (t0_gate_enable_i && !ext_a_q2 && t0_inc);

endmodule

// file: dtg_pkg.sv
package dtg_pkg;

    // operating modes, one field per timer
    typedef enum logic [1:0] {
        MODE_13BIT   = 2'b00,
        MODE_16BIT   = 2'b01,
        MODE_RELOAD8 = 2'b10,
        MODE_SPLIT8  = 2'b11
    } dtg_mode_type;

    // shared clock-scale field codes
    typedef enum logic [1:0] {
        SCALE_0 = 2'b00,
        SCALE_1 = 2'b01,
        SCALE_2 = 2'b10,
        SCALE_3 = 2'b11
    } dtg_scale_type;

    // prescaler divide ratios, one per scale code
    localparam logic [5:0] PRESC_DIV_0  = 6'h0C;
    localparam logic [5:0] PRESC_DIV_1  = 6'h04;
    localparam logic [5:0] PRESC_DIV_2  = 6'h30;
    localparam logic [5:0] PRESC_DIV_3  = 6'h08;
    localparam logic [5:0] PRESC_RESET  = 6'h00;
    localparam logic [5:0] PRESC_ONE    = 6'h01;

    // byte write strobe positions
    localparam int BYTE_T0_LOW  = 0;
    localparam int BYTE_T0_HIGH = 1;
    localparam int BYTE_T1_LOW  = 2;
    localparam int BYTE_T1_HIGH = 3;
    localparam int BYTE_COUNT   = 4;

    // counter layout and reset values
    localparam int         M0_LOW_W    = 5;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [7:0] BYTE_ONE    = 8'h01;
    localparam logic [12:0] CNT13_ONE  = 13'h0001;
    localparam logic [15:0] CNT16_ONE  = 16'h0001;

endpackage

// file: dtg_gate_model.sv
`timescale 1ns/100ps
module dtg_gate_model (
    // clock
    input  wire logic clk_i,
    // bench requests, high asks for an active (low) pin
    input  wire logic gate_a_act_i,
    input  wire logic gate_b_act_i,
    // gate pins, pulled up while nobody pulls them low
    output logic      ext_irq_in_a_n_o,
    output logic      ext_irq_in_b_n_o
);
    // pins idle at the pull-up level until asked to go active
    initial begin
        ext_irq_in_a_n_o = 1'b1;
        ext_irq_in_b_n_o = 1'b1;
    end

    // pins move just after the edge, so the synchronizer never sees a tie
    always @(posedge clk_i) begin
        ext_irq_in_a_n_o <= #1 ~gate_a_act_i;
        ext_irq_in_b_n_o <= #1 ~gate_b_act_i;
    end
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
    logic       clk_i, arst_n_i, run0, run1, t0_gate_enable, gate1, csel0, csel1, ie0, ie1;
    logic [1:0] mode0, mode1, scale;
    logic [3:0] byte_wr;
    logic [7:0] wdata, l0, h0, l1, h1;
    logic       clr0, clr1, ack0, ack1, ga, gb, pa_n, pb_n, f0, f1, q0, q1;
    int         err_count, check_count, cycles;

    // design and the gate pin driver
    dtg_gate_model GATE (.clk_i(clk_i), .gate_a_act_i(ga), .gate_b_act_i(gb),
        .ext_irq_in_a_n_o(pa_n), .ext_irq_in_b_n_o(pb_n));
    dtg_timer DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .t0_run_i(run0), .t1_run_i(run1),
        .t0_gate_enable_i(t0_gate_enable), .t1_gate_enable_i(gate1), .t0_mode_select_i(mode0),
        .t1_mode_select_i(mode1), .t0_clk_select_i(csel0), .t1_clk_select_i(csel1),
        .clock_scale_field_i(scale), .t0_irq_enable_i(ie0), .t1_irq_enable_i(ie1),
        .byte_wr_i(byte_wr), .byte_wdata_i(wdata), .t0_flag_clr_i(clr0),
        .t1_flag_clr_i(clr1), .t0_vector_ack_i(ack0), .t1_vector_ack_i(ack1),
        .ext_irq_in_a_n_i(pa_n), .ext_irq_in_b_n_i(pb_n), .t0_low_byte_o(l0),
        .t0_high_byte_o(h0), .t1_low_byte_o(l1), .t1_high_byte_o(h1),
        .t0_overflow_flag_o(f0), .t1_overflow_flag_o(f1), .t0_irq_o(q0), .t1_irq_o(q1));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // a hang is cut short well above the fewer than two hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // compare after the edge updates have landed
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe; an idle edge follows so a second call never
    // reassigns the strobe in the time step of its release
    task automatic wr(input logic [3:0] mask, input logic [7:0] d);
        byte_wr <= mask;
        wdata   <= d;
        cyc(1);
        byte_wr <= 4'h0;
        cyc(1);
    endtask

    // run for exactly n counting edges, then read one cycle later
    task automatic run_t0(input int n);
        run0 <= 1'b1;
        cyc(n);
        run0 <= 1'b0;
        cyc(1);
        #1;
    endtask

    // same as run_t0 for timer 1
    task automatic run_t1(input int n);
        run1 <= 1'b1;
        cyc(n);
        run1 <= 1'b0;
        cyc(1);
        #1;
    endtask

    task automatic t_reset;
        #1;
        chk(l0 | h0, 8'h00, "reset t0 bytes");
        chk(l1 | h1, 8'h00, "reset t1 bytes");
        chk({6'h00, f0, f1}, 8'h00, "reset flags");
        $display("test reset done");
    endtask

    task automatic t_mode13;
        mode0 <= dtg_pkg::MODE_13BIT;
        ie0   <= 1'b1;
        wr(4'h2, 8'hFF);
        wr(4'h1, 8'hFF);
        run_t0(1);
        chk(h0, 8'h00, "13 high");
        chk(l0 & 8'h1F, 8'h00, "13 low masked");
        chk({6'h00, f0, q0}, 8'h03, "13 flag irq");
        clr0 <= 1'b1;
        cyc(1);
        clr0 <= 1'b0;
        cyc(1);
        #1;
        chk({7'h00, f0}, 8'h00, "13 flag cleared");
        $display("test mode13 done");
    endtask

    task automatic t_reload;
        mode0 <= dtg_pkg::MODE_RELOAD8;
        wr(4'h2, 8'hA5);
        wr(4'h1, 8'hFE);
        run_t0(3);
        chk(l0, 8'hA6, "reload low");
        chk(h0, 8'hA5, "reload high kept");
        chk({7'h00, f0}, 8'h01, "reload flag");
        $display("test reload done");
    endtask

    task automatic t_gate;
        mode0 <= dtg_pkg::MODE_16BIT;
        t0_gate_enable <= 1'b1;
        wr(4'h3, 8'h00);
        run_t0(20);
        chk(l0, 8'h00, "gated off");
        ga <= 1'b1;
        cyc(5);
        run_t0(20);
        chk(l0, 8'h14, "gated on");
        run_t0(7);
        chk(l0, 8'h1B, "resume no clear");
        ga    <= 1'b0;
        t0_gate_enable <= 1'b0;
        $display("test gate done");
    endtask

    task automatic t_timer1;
        mode1 <= dtg_pkg::MODE_16BIT;
        wr(4'hC, 8'hFF);
        run1 <= 1'b1;
        cyc(1);
        run1 <= 1'b0;
        cyc(1);
        #1;
        chk(l1 | h1, 8'h00, "t1 wrap");
        chk({6'h00, f1, q1}, 8'h02, "t1 flag no irq");
        ack1 <= 1'b1;
        cyc(1);
        ack1 <= 1'b0;
        cyc(1);
        #1;
        chk({7'h00, f1}, 8'h00, "t1 ack clear");
        // prescaled tick, divide ratio taken from the package
        csel1 <= 1'b0;
        scale <= dtg_pkg::SCALE_1;
        cyc(4);
        run1 <= 1'b1;
        cyc(40);
        run1 <= 1'b0;
        cyc(1);
        #1;
        chk(l1, 8'(40 / int'(dtg_pkg::PRESC_DIV_1)), "prescaled count");
        $display("test timer1 done");
    endtask

    // timer 1 gate pin: high level blocks, low level lets it count
    task automatic t_gate1;
        csel1 <= 1'b1;
        gate1 <= 1'b1;
        wr(4'hC, 8'h00);
        run_t1(10);
        chk(l1, 8'h00, "t1 gated off");
        gb <= 1'b1;
        cyc(5);
        run_t1(5);
        chk(l1, 8'h05, "t1 gated on");
        gb    <= 1'b0;
        gate1 <= 1'b0;
        $display("test gate1 done");
    endtask

    task automatic t_split;
        mode0 <= dtg_pkg::MODE_SPLIT8;
        mode1 <= dtg_pkg::MODE_SPLIT8;
        ie1   <= 1'b1;
        wr(4'h3, 8'hFF);
        run1 <= 1'b1;
        cyc(1);
        run1 <= 1'b0;
        cyc(1);
        #1;
        chk(h0, 8'h00, "split high");
        chk(l0, 8'hFF, "split low idle");
        chk({6'h00, f1, q1}, 8'h03, "split sets t1 flag irq");
        chk(l1, 8'h05, "t1 stopped in split");
        // software clear on timer 1, vector acknowledge on timer 0
        clr1 <= 1'b1;
        ack0 <= 1'b1;
        cyc(1);
        clr1 <= 1'b0;
        ack0 <= 1'b0;
        cyc(1);
        #1;
        chk({5'h00, f0, f1, q1}, 8'h00, "split flags cleared");
        $display("test split done");
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {run0, run1, t0_gate_enable, gate1, ie0, ie1, clr0, clr1, ack0, ack1, ga, gb} = '0;
        {csel0, csel1} = 2'b11;
        {mode0, mode1, scale} = '0;
        {byte_wr, wdata} = '0;
        {err_count, check_count, cycles} = '0;
        arst_n_i = 1'b0;
        cyc(16);
        arst_n_i <= 1'b1;
        t_reset();
        t_mode13();
        t_reload();
        t_gate();
        t_timer1();
        t_gate1();
        t_split();
        close_out();
    end
endmodule
